// ---- rtl/vcw_config.sv ----
// Notes on behaviour
// - Input select config resets to 0x58.
// - Selector 01/10/11 route inputs two/zero/one.
// - Enhanced part: selector 00 routes input three.
// - Crystal selector: 01 zero, 10 one, 11 auto.
// - Standard selector decodes six standards at 001-110, 000 auto.
// - Auto standard follows line count status bit.
// - Enhanced part: standard 111 is PAL N-combination.
// - Drop control resets zero, discards chosen fields.
// - Bit 7 picks frame or field dropping.
// - Bit 6 picks parity of first drop.
// - Ratio drops N of 60/50; zero disables.
// - Upper bits reset 0x12, four two-bit fields.
// - Vertical start top bits swap even/odd addresses.
// - Vertical start counts half lines after sync reset.
// - Vertical window lines are ten bits.
// - Horizontal start counts scaled pixels after sync.
// - Separate even/odd copies switch on field indicator.
// - Data on byte lane 0; upper lanes zero.
// - Line count status: 0 is 525, 1 is 625.
`timescale 1ns/1ns
`default_nettype none
`include "vcw_defs.svh"

module vcw_config #(
  parameter bit ENHANCED = 1'b1
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire vcw_pkg::vcw_req_s    req,
  output logic [31:0]               reg_rdata,
  output logic                      reg_rvalid,
  input  wire logic                 line_count_status,
  input  wire logic                 field_start,
  input  wire logic                 field_even,
  input  wire logic                 vertical_sync_reset,
  input  wire logic                 half_line_tick,
  input  wire logic                 line_tick,
  input  wire logic                 horizontal_sync_reset,
  input  wire logic                 scaled_pixel_tick,
  output logic [3:0]                analog_mux_output,
  output logic                      crystal_zero,
  output logic                      crystal_one,
  output vcw_pkg::vcw_std_e         standard,
  output logic                      capture_enable,
  output vcw_pkg::vcw_window_s      window,
  output logic                      vert_active_video,
  output logic                      horiz_active_video
);

  // ****************************************************************
  // Address decode
  // ****************************************************************

  // Maps a dword address to a register; unused addresses give none
  function automatic vcw_pkg::vcw_reg_e decode(input logic [11:2] a);
    logic [11:0] byte_addr;
    byte_addr = {a, 2'b00};
    case (byte_addr)
      `VCW_OFS_INPUT_SELECT_CONFIG:  decode = vcw_pkg::VCW_REG_ISC;
      `VCW_OFS_FIELD_DROP_CONTROL:   decode = vcw_pkg::VCW_REG_FDC;
      `VCW_OFS_WINDOW_UPPER_EVEN:    decode = vcw_pkg::VCW_REG_UPR_E;
      `VCW_OFS_VERT_DELAY_LOW_EVEN:  decode = vcw_pkg::VCW_REG_VDL_E;
      `VCW_OFS_VERT_ACTIVE_LOW_EVEN: decode = vcw_pkg::VCW_REG_VAL_E;
      `VCW_OFS_HORIZ_DELAY_LOW_EVEN: decode = vcw_pkg::VCW_REG_HDL_E;
      `VCW_OFS_WINDOW_UPPER_ODD:     decode = vcw_pkg::VCW_REG_UPR_O;
      `VCW_OFS_VERT_DELAY_LOW_ODD:   decode = vcw_pkg::VCW_REG_VDL_O;
      `VCW_OFS_VERT_ACTIVE_LOW_ODD:  decode = vcw_pkg::VCW_REG_VAL_O;
      `VCW_OFS_HORIZ_DELAY_LOW_ODD:  decode = vcw_pkg::VCW_REG_HDL_O;
      default:                       decode = vcw_pkg::VCW_REG_NONE;
    endcase
  endfunction : decode

  vcw_pkg::vcw_reg_e sel;
  logic              wr_lane0;

  // Only byte lane 0 carries data, so a write without it stores nothing
  assign sel      = decode(req.addr);
  assign wr_lane0 = req.wr && req.be[0];

  // ****************************************************************
  // Register storage
  // ****************************************************************

  logic [7:0] isc_q;
  logic [7:0] fdc_q;
  logic [5:0] upr_q      [2];   // Index 0 even, 1 odd; bits [5:0] only
  logic [1:0] vtop_q     [2];   // Vertical start top bits per field
  logic [7:0] vdl_q      [2];
  logic [7:0] val_q      [2];
  logic [7:0] hdl_q      [2];

  // Upper-bits reset held as a value so that its fields can be sliced
  localparam logic [7:0] UPR_RST = `VCW_RST_WINDOW_UPPER;

  // Input select and drop control
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      isc_q <= `VCW_RST_INPUT_SELECT_CONFIG;
      fdc_q <= `VCW_RST_FIELD_DROP_CONTROL;
    end
    else if (wr_lane0)
    begin
      // Reserved bit 7 is stored as written and steers nothing
      if (sel == vcw_pkg::VCW_REG_ISC)
        isc_q <= req.wdata[7:0];
      if (sel == vcw_pkg::VCW_REG_FDC)
        fdc_q <= req.wdata[7:0];
    end
  end

  // Upper-bits registers; vertical start top bits land in the other field
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int f = 0; f < 2; f++)
      begin
        upr_q[f]  <= UPR_RST[5:0];
        vtop_q[f] <= UPR_RST[`VCW_UPR_VSTART];
      end
    end
    else if (wr_lane0)
    begin
      if (sel == vcw_pkg::VCW_REG_UPR_E)
      begin
        upr_q[0]  <= req.wdata[5:0];
        vtop_q[1] <= req.wdata[`VCW_UPR_VSTART];
      end
      if (sel == vcw_pkg::VCW_REG_UPR_O)
      begin
        upr_q[1]  <= req.wdata[5:0];
        vtop_q[0] <= req.wdata[`VCW_UPR_VSTART];
      end
    end
  end

  // Low bytes of the window values, one copy per field
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int f = 0; f < 2; f++)
      begin
        vdl_q[f] <= `VCW_RST_VERT_DELAY_LOW;
        val_q[f] <= `VCW_RST_VERT_ACTIVE_LOW;
        hdl_q[f] <= `VCW_RST_HORIZ_DELAY_LOW;
      end
    end
    else if (wr_lane0)
    begin
      case (sel)
        vcw_pkg::VCW_REG_VDL_E: vdl_q[0] <= req.wdata[7:0];
        vcw_pkg::VCW_REG_VAL_E: val_q[0] <= req.wdata[7:0];
        vcw_pkg::VCW_REG_HDL_E: hdl_q[0] <= req.wdata[7:0];
        vcw_pkg::VCW_REG_VDL_O: vdl_q[1] <= req.wdata[7:0];
        vcw_pkg::VCW_REG_VAL_O: val_q[1] <= req.wdata[7:0];
        vcw_pkg::VCW_REG_HDL_O: hdl_q[1] <= req.wdata[7:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************

  logic [7:0] rd_byte;

  // Upper-bits readback mirrors the write mapping, swap included
  always_comb
  begin
    case (sel)
      vcw_pkg::VCW_REG_ISC:   rd_byte = isc_q;
      vcw_pkg::VCW_REG_FDC:   rd_byte = fdc_q;
      vcw_pkg::VCW_REG_UPR_E: rd_byte = {vtop_q[1], upr_q[0]};
      vcw_pkg::VCW_REG_VDL_E: rd_byte = vdl_q[0];
      vcw_pkg::VCW_REG_VAL_E: rd_byte = val_q[0];
      vcw_pkg::VCW_REG_HDL_E: rd_byte = hdl_q[0];
      vcw_pkg::VCW_REG_UPR_O: rd_byte = {vtop_q[0], upr_q[1]};
      vcw_pkg::VCW_REG_VDL_O: rd_byte = vdl_q[1];
      vcw_pkg::VCW_REG_VAL_O: rd_byte = val_q[1];
      vcw_pkg::VCW_REG_HDL_O: rd_byte = hdl_q[1];
      default:                rd_byte = 8'h00;  // Unused reads as zero
    endcase
  end

  // Read data one cycle after the request; upper lanes always zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_rdata  <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= req.rd;
      reg_rdata  <= {24'h00_0000, (req.rd && req.be[0]) ? rd_byte : 8'h00};
    end
  end

  // ****************************************************************
  // Input, crystal and standard selection
  // ****************************************************************

  logic [1:0] mux_code;
  logic [1:0] xt_code;
  logic [2:0] std_code;

  assign mux_code = isc_q[`VCW_ISC_SELECTOR];
  assign xt_code  = isc_q[`VCW_ISC_CRYSTAL];
  assign std_code = isc_q[`VCW_ISC_STANDARD];

  // One-hot analog route; reserved code on the base part routes nothing
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      analog_mux_output <= 4'h0;
    else
    begin
      case (mux_code)
        2'b01:   analog_mux_output <= 4'h4;
        2'b10:   analog_mux_output <= 4'h1;
        2'b11:   analog_mux_output <= 4'h2;
        default: analog_mux_output <= ENHANCED ? 4'h8 : 4'h0;
      endcase
    end
  end

  // Auto mode takes crystal one for 625-line video, zero for 525
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      crystal_zero <= 1'b0;
      crystal_one  <= 1'b0;
    end
    else
    begin
      case (xt_code)
        2'b01:
        begin
          crystal_zero <= 1'b1;
          crystal_one  <= 1'b0;
        end
        2'b10:
        begin
          crystal_zero <= 1'b0;
          crystal_one  <= 1'b1;
        end
        2'b11:
        begin
          crystal_zero <= !line_count_status;
          crystal_one  <= line_count_status;
        end
        default:
        begin
          crystal_zero <= 1'b0;
          crystal_one  <= 1'b0;
        end
      endcase
    end
  end

  // Standard in force; reserved 111 on the base part falls back to auto
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      standard <= vcw_pkg::VCW_STD_NTSC_M;
    else if (std_code == 3'b000 || (std_code == 3'b111 && !ENHANCED))
      standard <= line_count_status ? vcw_pkg::VCW_STD_PAL_BDGHI
                                    : vcw_pkg::VCW_STD_NTSC_M;
    else
      standard <= vcw_pkg::vcw_std_e'(std_code);
  end

  // ****************************************************************
  // Temporal decimation
  // ****************************************************************

  logic       drop_q;
  logic       armed_q;
  logic [6:0] acc_q;
  logic [6:0] period;
  logic [6:0] ratio;
  logic [6:0] sum;
  logic       first_parity;
  logic       frame_head;

  assign period       = line_count_status ? `VCW_PERIOD_625 : `VCW_PERIOD_525;
  assign ratio        = {1'b0, fdc_q[`VCW_FDC_RATIO]};
  assign sum          = acc_q + ratio;
  assign first_parity = fdc_q[`VCW_FDC_PARITY];
  assign frame_head   = (field_even == first_parity);

  // Error accumulator spreads drops evenly; a rewrite restarts alignment
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      drop_q  <= 1'b0;
      armed_q <= 1'b0;
      acc_q   <= 7'h00;
    end
    else if (wr_lane0 && sel == vcw_pkg::VCW_REG_FDC)
    begin
      drop_q  <= 1'b0;
      armed_q <= 1'b0;
      acc_q   <= 7'h00;
    end
    else if (field_start)
    begin
      if (ratio == 7'h00)
      begin
        drop_q  <= 1'b0;
        armed_q <= 1'b0;
      end
      else if (!armed_q)
      begin
        // First drop lands on the chosen parity
        drop_q  <= frame_head;
        armed_q <= frame_head;
        acc_q   <= 7'h00;
      end
      else if (fdc_q[`VCW_FDC_UNIT] || frame_head)
      begin
        // Per field, or at the head of each frame
        if (sum >= period)
        begin
          drop_q <= 1'b1;
          acc_q  <= (ratio >= period) ? acc_q : sum - period;   // No carry growth when all drop
        end
        else
        begin
          drop_q <= 1'b0;
          acc_q  <= sum;
        end
      end
      // Second field of a frame keeps the frame's decision
    end
  end

  assign capture_enable = !drop_q;

  // ****************************************************************
  // Field window and start counters
  // ****************************************************************

  // Copies switch only at a field start so a field in progress is stable
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      window <= '{vert_start_offset:    {UPR_RST[`VCW_UPR_VSTART],
                                         `VCW_RST_VERT_DELAY_LOW},
                  vert_window_lines:    {UPR_RST[`VCW_UPR_VLINES],
                                         `VCW_RST_VERT_ACTIVE_LOW},
                  horiz_start_offset:   {UPR_RST[`VCW_UPR_HSTART],
                                         `VCW_RST_HORIZ_DELAY_LOW},
                  horiz_window_top_bits: UPR_RST[`VCW_UPR_HPIXELS]};
    else if (field_start)
    begin
      for (int f = 0; f < 2; f++)
      begin
        if ((f == 0) == field_even)
        begin
          window.vert_start_offset     <= {vtop_q[f], vdl_q[f]};
          window.vert_window_lines     <= {upr_q[f][`VCW_UPR_VLINES], val_q[f]};
          window.horiz_start_offset    <= {upr_q[f][`VCW_UPR_HSTART], hdl_q[f]};
          window.horiz_window_top_bits <= upr_q[f][`VCW_UPR_HPIXELS];
        end
      end
    end
  end

  logic       vsr_prev_q;
  logic       hsr_prev_q;
  logic [9:0] half_cnt_q;
  logic [9:0] line_cnt_q;
  logic [9:0] pix_cnt_q;
  logic       v_wait_q;
  logic       h_wait_q;

  // Previous sync levels for trailing and falling edges
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      vsr_prev_q <= 1'b0;
      hsr_prev_q <= 1'b0;
    end
    else
    begin
      vsr_prev_q <= vertical_sync_reset;
      hsr_prev_q <= horizontal_sync_reset;
    end
  end

  // Half lines to active video, then lines of the vertical window
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      half_cnt_q        <= 10'h000;
      line_cnt_q        <= 10'h000;
      v_wait_q          <= 1'b0;
      vert_active_video <= 1'b0;
    end
    else if (vsr_prev_q && !vertical_sync_reset)
    begin
      half_cnt_q        <= 10'h000;
      line_cnt_q        <= 10'h000;
      v_wait_q          <= 1'b1;
      vert_active_video <= 1'b0;
    end
    else if (v_wait_q && half_cnt_q == window.vert_start_offset)
    begin
      v_wait_q          <= 1'b0;
      vert_active_video <= (window.vert_window_lines != 10'h000);
    end
    else if (v_wait_q && half_line_tick)
      half_cnt_q <= half_cnt_q + 10'h001;
    else if (vert_active_video && line_tick)
    begin
      line_cnt_q <= line_cnt_q + 10'h001;
      if (line_cnt_q + 10'h001 >= window.vert_window_lines)
        vert_active_video <= 1'b0;
    end
  end

  // Scaled pixels from the fall of horizontal sync reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pix_cnt_q          <= 10'h000;
      h_wait_q           <= 1'b0;
      horiz_active_video <= 1'b0;
    end
    else if (hsr_prev_q && !horizontal_sync_reset)
    begin
      pix_cnt_q          <= 10'h000;
      h_wait_q           <= 1'b1;
      horiz_active_video <= 1'b0;
    end
    else if (h_wait_q && pix_cnt_q == window.horiz_start_offset)
    begin
      h_wait_q           <= 1'b0;
      horiz_active_video <= 1'b1;
    end
    else if (h_wait_q && scaled_pixel_tick)
      pix_cnt_q <= pix_cnt_q + 10'h001;
  end

endmodule : vcw_config
`default_nettype wire

// ---- include/vcw_defs.svh ----
`ifndef VCW_DEFS_SVH
`define VCW_DEFS_SVH

// ****************************************************************
// Register byte addresses (PCI memory space, 4 KB window)
// ****************************************************************
`define VCW_OFS_INPUT_SELECT_CONFIG   12'h004
`define VCW_OFS_FIELD_DROP_CONTROL    12'h008
`define VCW_OFS_WINDOW_UPPER_EVEN     12'h00C
`define VCW_OFS_VERT_DELAY_LOW_EVEN   12'h010
`define VCW_OFS_VERT_ACTIVE_LOW_EVEN  12'h014
`define VCW_OFS_HORIZ_DELAY_LOW_EVEN  12'h018
`define VCW_OFS_WINDOW_UPPER_ODD      12'h08C
`define VCW_OFS_VERT_DELAY_LOW_ODD    12'h090
`define VCW_OFS_VERT_ACTIVE_LOW_ODD   12'h094
`define VCW_OFS_HORIZ_DELAY_LOW_ODD   12'h098

// ****************************************************************
// Reset values
// ****************************************************************
`define VCW_RST_INPUT_SELECT_CONFIG   8'h58
`define VCW_RST_FIELD_DROP_CONTROL    8'h00
`define VCW_RST_WINDOW_UPPER          8'h12
`define VCW_RST_VERT_DELAY_LOW        8'h16
`define VCW_RST_VERT_ACTIVE_LOW       8'hE0
`define VCW_RST_HORIZ_DELAY_LOW       8'h78

// ****************************************************************
// Field positions
// ****************************************************************
`define VCW_ISC_SELECTOR              6:5
`define VCW_ISC_CRYSTAL               4:3
`define VCW_ISC_STANDARD              2:0
`define VCW_FDC_UNIT                  7
`define VCW_FDC_PARITY                6
`define VCW_FDC_RATIO                 5:0
`define VCW_UPR_VSTART                7:6
`define VCW_UPR_VLINES                5:4
`define VCW_UPR_HSTART                3:2
`define VCW_UPR_HPIXELS               1:0

// ****************************************************************
// Drop periods in fields or frames
// ****************************************************************
`define VCW_PERIOD_525                7'h3C
`define VCW_PERIOD_625                7'h32

`endif

// ---- include/vcw_pkg.sv ----
package vcw_pkg;

  // Register selected by a decoded address
  typedef enum logic [3:0] {
    VCW_REG_NONE   = 4'b0000,
    VCW_REG_ISC    = 4'b0001,
    VCW_REG_FDC    = 4'b0010,
    VCW_REG_UPR_E  = 4'b0011,
    VCW_REG_VDL_E  = 4'b0100,
    VCW_REG_VAL_E  = 4'b0101,
    VCW_REG_HDL_E  = 4'b0110,
    VCW_REG_UPR_O  = 4'b0111,
    VCW_REG_VDL_O  = 4'b1000,
    VCW_REG_VAL_O  = 4'b1001,
    VCW_REG_HDL_O  = 4'b1010
  } vcw_reg_e;

  // Video standard in use
  typedef enum logic [2:0] {
    VCW_STD_AUTO     = 3'b000,
    VCW_STD_NTSC_M   = 3'b001,
    VCW_STD_NTSC_NP  = 3'b010,
    VCW_STD_PAL_BDGHI = 3'b011,
    VCW_STD_PAL_M    = 3'b100,
    VCW_STD_PAL_N    = 3'b101,
    VCW_STD_SECAM    = 3'b110,
    VCW_STD_PAL_NC   = 3'b111
  } vcw_std_e;

  // Window in force for the current field
  typedef struct packed {
    logic [9:0] vert_start_offset;
    logic [9:0] vert_window_lines;
    logic [9:0] horiz_start_offset;
    logic [1:0] horiz_window_top_bits;
  } vcw_window_s;

  // Register port request
  typedef struct packed {
    logic [11:2] addr;
    logic [3:0]  be;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
  } vcw_req_s;

endpackage : vcw_pkg

// ---- verif/vcw_config_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none

module vcw_config_asserts #(
  parameter bit ENHANCED = 1'b1
) (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire vcw_pkg::vcw_req_s    req,
  input wire logic [31:0]          reg_rdata,
  input wire logic                 reg_rvalid,
  input wire logic                 field_start,
  input wire logic [3:0]           analog_mux_output,
  input wire logic                 crystal_zero,
  input wire logic                 crystal_one,
  input wire vcw_pkg::vcw_std_e    standard,
  input wire logic                 capture_enable,
  input wire vcw_pkg::vcw_window_s window,
  input wire logic                 vert_active_video
);
  // ************
  // Properties
  // ************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // One-hot route expected for a selector code
  function automatic logic [3:0] route(input logic [1:0] sel);
    case (sel)
      2'b01:   route = 4'h4;
      2'b10:   route = 4'h1;
      2'b11:   route = 4'h2;
      default: route = ENHANCED ? 4'h8 : 4'h0;
    endcase
  endfunction : route

  // Write to the input select register, and spells without field or write activity
  sequence isc_write;
    req.wr && req.be[0] && req.addr == 10'h001;
  endsequence
  sequence field_quiet;
    !field_start [*2];
  endsequence
  sequence ctrl_quiet;
    (!field_start && !req.wr) [*2];
  endsequence

  AST_RD_VALID: assert property (req.rd |=> reg_rvalid)
    else $error("read not answered");
  AST_UPPER_LANES: assert property (reg_rvalid |-> reg_rdata[31:8] == 24'h0)
    else $error("upper lanes not zero");
  AST_LANE0_OFF: assert property (req.rd && !req.be[0] |=> reg_rdata == 32'h0)
    else $error("disabled lane returned data");
  AST_MUX_ROUTE: assert property (isc_write |-> ##2
    analog_mux_output == route($past(req.wdata[6:5], 2)))
    else $error("wrong input routed");
  AST_STD_MANUAL: assert property (isc_write ##0 (req.wdata[2:0] != 3'b000)
    ##0 (ENHANCED || req.wdata[2:0] != 3'b111) |-> ##2 standard == $past(req.wdata[2:0], 2))
    else $error("manual standard not applied");
  AST_XTAL_EXCL: assert property (!(crystal_zero && crystal_one))
    else $error("both crystals in use");
  AST_WINDOW_HOLD: assert property (field_quiet |=> $stable(window))
    else $error("window changed inside a field");
  AST_DROP_HOLD: assert property (ctrl_quiet |=> $stable(capture_enable))
    else $error("drop decision changed inside a field");
  AST_VLINES_SET: assert property ($rose(vert_active_video) |->
    window.vert_window_lines != 10'h000)
    else $error("active video with empty window");
endmodule : vcw_config_asserts

bind vcw_config vcw_config_asserts #(.ENHANCED(ENHANCED)) vcw_config_asserts_inst (
  .clk(clk), .rst_n(rst_n), .req(req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .field_start(field_start), .analog_mux_output(analog_mux_output),
  .crystal_zero(crystal_zero), .crystal_one(crystal_one), .standard(standard),
  .capture_enable(capture_enable), .window(window), .vert_active_video(vert_active_video)
);

`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "vcw_defs.svh"

module testbench;
  // ************
  // Signals
  // ************
  logic                 clk;
  logic                 rst_n;
  vcw_pkg::vcw_req_s    req;
  logic [31:0]          reg_rdata;
  logic                 reg_rvalid;
  logic                 line_count_status;
  logic                 field_start;
  logic                 field_even;
  logic                 vertical_sync_reset;
  logic                 half_line_tick;
  logic                 line_tick;
  logic                 horizontal_sync_reset;
  logic                 scaled_pixel_tick;
  logic [3:0]           analog_mux_output;
  logic                 crystal_zero;
  logic                 crystal_one;
  vcw_pkg::vcw_std_e    standard;
  logic                 capture_enable;
  vcw_pkg::vcw_window_s window;
  logic                 vert_active_video;
  logic                 horiz_active_video;
  int                   num_errors;
  int                   compares;
  int                   drops;
  int                   first;
  logic [11:0] ofs  [10] = '{12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018,
                             12'h08C, 12'h090, 12'h094, 12'h098};
  logic [7:0]  rstv [10] = '{8'h58, 8'h00, 8'h12, 8'h16, 8'hE0, 8'h78,
                             8'h12, 8'h16, 8'hE0, 8'h78};
  logic [7:0]  pat  [10] = '{8'h4A, 8'h80, 8'h64, 8'h03, 8'h21, 8'h45,
                             8'h0B, 8'h67, 8'h89, 8'hAB};
  logic [3:0]  mexp [4]  = '{4'h8, 4'h4, 4'h1, 4'h2};

  vcw_config vcw_config_inst (
    .clk(clk), .rst_n(rst_n), .req(req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .line_count_status(line_count_status), .field_start(field_start),
    .field_even(field_even), .vertical_sync_reset(vertical_sync_reset),
    .half_line_tick(half_line_tick), .line_tick(line_tick),
    .horizontal_sync_reset(horizontal_sync_reset), .scaled_pixel_tick(scaled_pixel_tick),
    .analog_mux_output(analog_mux_output), .crystal_zero(crystal_zero),
    .crystal_one(crystal_one), .standard(standard), .capture_enable(capture_enable),
    .window(window), .vert_active_video(vert_active_video),
    .horiz_active_video(horiz_active_video)
  );

  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ************
  // Tasks
  // ************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Upper lanes carry junk on purpose; only lane 0 may count
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge clk);
    req <= '{a[11:2], be, 1'b1, 1'b0, {24'hA5C3E1, d}};
    @(posedge clk);
    req <= '0;
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [3:0] be, input logic [7:0] e);
    @(posedge clk);
    req <= '{a[11:2], be, 1'b0, 1'b1, 32'h0};
    @(posedge clk);
    req <= '0;
    #1;
    chk({31'h0, reg_rvalid}, 32'h1);
    chk(reg_rdata, {24'h0, e});
  endtask : rd_chk

  task automatic fld(input logic even);
    @(posedge clk);
    field_start <= 1'b1;
    field_even <= even;
    @(posedge clk);
    field_start <= 1'b0;
    cyc(1);
  endtask : fld

  task automatic tick;
    @(posedge clk);
    half_line_tick <= 1'b1;
    @(posedge clk);
    half_line_tick <= 1'b0;
    cyc(1);
  endtask : tick

  // Fields alternate starting with even; records drops and the first dropped index
  task automatic run_fields(input int n, input logic spread);
    logic prev;
    prev = 1'b0;
    drops = 0;
    first = -1;
    for (int i = 0; i < n; i++)
    begin
      fld(i % 2 == 0);
      if (spread) chk({31'h0, prev & ~capture_enable}, 32'h0);
      if (capture_enable === 1'b0 && first < 0) first = i;
      if (capture_enable === 1'b0) drops++;
      prev = ~capture_enable;
    end
  endtask : run_fields

  task automatic wrap_up;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  // Watchdog, far beyond the roughly 1400 cycles the tests need
  initial
  begin
    #40000;
    num_errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    wrap_up();
  end

  // ************
  // Tests
  // ************
  initial
  begin
    req = '0;
    rst_n = 1'b0;
    {line_count_status, field_start, field_even, vertical_sync_reset} = 4'h0;
    {half_line_tick, line_tick, horizontal_sync_reset, scaled_pixel_tick} = 4'h0;
    num_errors = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) rd_chk(ofs[i], 4'hF, rstv[i]);
    for (int i = 0; i < 10; i++) wr(ofs[i], pat[i], 4'h1);
    chk(window, {10'h016, 10'h1E0, 10'h078, 2'b10});
    for (int i = 0; i < 10; i++) rd_chk(ofs[i], 4'hF, pat[i]);
    wr(ofs[3], 8'hEE, 4'hE);
    rd_chk(ofs[3], 4'hE, 8'h00);
    rd_chk(ofs[3], 4'h1, 8'h03);
    wr(12'h0F0, 8'h5A, 4'h1);
    rd_chk(12'h0F0, 4'h1, 8'h00);
    // Field copies, with vertical start top bits crossed over
    fld(1'b1);
    chk(window, {10'h003, 10'h221, 10'h145, 2'b00});
    fld(1'b0);
    chk(window, {10'h167, 10'h089, 10'h2AB, 2'b11});
    fld(1'b1);
    @(posedge clk) vertical_sync_reset <= 1'b1;
    @(posedge clk) vertical_sync_reset <= 1'b0;
    cyc(2);
    repeat (2) tick();
    chk({31'h0, vert_active_video}, 32'h0);
    tick();
    chk({31'h0, vert_active_video}, 32'h1);
    // Ticks every cycle: 0x145 pixels to start, 0x221 lines of window
    @(posedge clk) horizontal_sync_reset <= 1'b1;
    @(posedge clk) {horizontal_sync_reset, scaled_pixel_tick, line_tick} <= 3'b011;
    cyc(326);
    chk({31'h0, horiz_active_video}, 32'h0);
    cyc(1);
    chk({31'h0, horiz_active_video}, 32'h1);
    cyc(217);
    chk({31'h0, vert_active_video}, 32'h1);
    cyc(1);
    chk({31'h0, vert_active_video}, 32'h0);
    // Every selector, crystal and standard code
    for (int s = 0; s < 4; s++)
    begin
      wr(`VCW_OFS_INPUT_SELECT_CONFIG, {1'b0, s[1:0], 5'b01001}, 4'h1);
      cyc(1);
      chk({28'h0, analog_mux_output}, {28'h0, mexp[s]});
      chk({30'h0, crystal_zero, crystal_one}, 32'h2);
    end
    for (int s = 1; s < 8; s++)
    begin
      wr(`VCW_OFS_INPUT_SELECT_CONFIG, {5'b01010, s[2:0]}, 4'h1);
      cyc(1);
      chk({29'h0, standard}, {29'h0, s[2:0]});
      chk({30'h0, crystal_zero, crystal_one}, 32'h1);
    end
    for (int l = 0; l < 2; l++)
    begin
      @(posedge clk) line_count_status <= l[0];
      wr(`VCW_OFS_INPUT_SELECT_CONFIG, 8'h58, 4'h1);
      cyc(1);
      chk({29'h0, standard}, l ? 32'h3 : 32'h1);
      chk({30'h0, crystal_zero, crystal_one}, l ? 32'h1 : 32'h2);
    end
    // Reserved crystal code leaves both crystals unused
    wr(`VCW_OFS_INPUT_SELECT_CONFIG, 8'h40, 4'h1);
    cyc(1);
    chk({30'h0, crystal_zero, crystal_one}, 32'h0);
    // Dropping by field and by frame over full periods
    @(posedge clk) line_count_status <= 1'b0;
    wr(`VCW_OFS_FIELD_DROP_CONTROL, 8'h9E, 4'h1);
    run_fields(61, 1'b1);
    chk(drops, 30);
    chk(first, 1);
    wr(`VCW_OFS_FIELD_DROP_CONTROL, 8'hDE, 4'h1);
    run_fields(60, 1'b1);
    chk(drops, 30);
    chk(first, 0);
    @(posedge clk) line_count_status <= 1'b1;
    wr(`VCW_OFS_FIELD_DROP_CONTROL, 8'h19, 4'h1);
    run_fields(101, 1'b0);
    chk(drops, 50);
    wr(`VCW_OFS_FIELD_DROP_CONTROL, 8'h80, 4'h1);
    run_fields(20, 1'b0);
    chk(drops, 0);
    wrap_up();
  end
endmodule : testbench

`default_nettype wire
